// File: rsq_reset_sequencer.sv
// Chip-level reset sequencer with its small register file.
// Assumes a synchronous host register port and a 200 MHz clock.
//
// Overview of operation
// - Five reset sources: power-on, pin, soft reset, two PHY reset bits.
// - Power-on holds internal reset about 22 ms by internal timer.
// - Ready reads 0 during power-on reset, then 1 when complete.
// - Pin low resets device; ready clear until done, then set.
// - Reset pin has internal pull-up, inactive when unconnected.
// - After wake write to byte-order register, ready sets within 2 ms.
// - Soft reset bit 0 of hardware config self-clears after 2 us.
// - Soft reset keeps registers marked immune unchanged.
// - PHY reset bit 10 of power control self-clears after 100 us.
// - PHY basic control bit 15 self-clears when PHY reset completes.
// - After chip resets, EEPROM probe runs, shown by busy bit 31.
// - Write to byte-order register in sleep returns to full-on mode.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module rsq_reset_sequencer
  import rsq_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES,
  parameter int unsigned WAKE_CNT = WAKE_CYCLES,
  parameter int unsigned PHY_RST_CNT = PHY_RST_CYCLES,
  parameter int unsigned PHY_REG_RST_CNT = PHY_REG_RST_CYCLES
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hw_reset_pin_n_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_q,
  // Reset outputs to the rest of the chip
  output logic chip_rst_n_q,
  output logic soft_rst_n_q,
  output logic phy_rst_n_q,
  output logic hw_reset_pin_pullup_q
);

  rsq_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] phy_cnt_q;
  logic [CNT_W-1:0] ee_cnt_q;
  logic ready_q;
  logic soft_reset_trigger_q;
  logic phy_rst_bit_q;
  logic phy_reg_rst_q;
  logic eeprom_busy_q;
  logic [PMC_MODE_W-1:0] power_state_select_q;
  logic [PHYBC_W-1:0] phy_basic_ctrl_q;
  logic [DATA_W-1:0] scratch_q;
  logic [DATA_W-1:0] immune_q;
  logic sync1_q;
  logic sync2_q;
  logic chip_rst_n;
  logic wr_byte_test;
  logic wr_hardware_config;
  logic wr_pmc;
  logic wr_phybc;
  logic soft_req;
  logic phy_req;
  logic phyreg_req;
  logic [DATA_W-1:0] rd_d;

  // Combined async source; pin pull-up means an open pin reads high
  assign chip_rst_n = rst_n & hw_reset_pin_n_in;

  // Release synchronised, assertion immediate
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= 1'b1;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hw_reset_pin_pullup_q <= 1'b0;
    else
      hw_reset_pin_pullup_q <= 1'b1;
  end

  assign wr_byte_test = reg_wr && reg_addr == ADDR_BYTE_TEST;
  assign wr_hardware_config = reg_wr && reg_addr == ADDR_HW_CONFIG;
  assign wr_pmc = reg_wr && reg_addr == ADDR_PWR_MGMT;
  assign wr_phybc = reg_wr && reg_addr == ADDR_PHY_BASIC_CTRL;
  assign soft_req = wr_hardware_config && reg_wdata[HWCFG_SOFT_RST_BIT];
  assign phy_req = wr_pmc && reg_wdata[PMC_PHY_RST_BIT];
  assign phyreg_req = wr_phybc && reg_wdata[PHYBC_RST_BIT];

  // Sequencer: power-on or pin timer, soft reset, wake
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      state_q <= RSQ_CHIP_RST;
      cnt_q <= CNT_ZERO;
      ready_q <= 1'b0;
      soft_reset_trigger_q <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        RSQ_CHIP_RST:
        begin
          // Synchroniser output gates the timer start
          if (sync2_q)
          begin
            if (cnt_q >= CNT_W'(POR_CNT - 1))
            begin
              state_q <= RSQ_RUN;
              ready_q <= 1'b1;
              cnt_q <= CNT_ZERO;
            end
            else
              cnt_q <= cnt_q + CNT_ONE;
          end
        end
        RSQ_SOFT_RST:
        begin
          if (cnt_q >= CNT_W'(SOFT_RST_CYCLES - 1))
          begin
            state_q <= RSQ_RUN;
            soft_reset_trigger_q <= 1'b0;
            ready_q <= 1'b1;
            cnt_q <= CNT_ZERO;
          end
          else
            cnt_q <= cnt_q + CNT_ONE;
        end
        RSQ_WAKING:
        begin
          if (cnt_q >= CNT_W'(WAKE_CNT - 1))
          begin
            state_q <= RSQ_RUN;
            ready_q <= 1'b1;
            cnt_q <= CNT_ZERO;
          end
          else
            cnt_q <= cnt_q + CNT_ONE;
        end
        RSQ_RUN:
        begin
          if (soft_req)
          begin
            state_q <= RSQ_SOFT_RST;
            soft_reset_trigger_q <= 1'b1;
            ready_q <= 1'b0;
          end
          else if (wr_byte_test && power_state_select_q != MODE_FULL_ON)
          begin
            state_q <= RSQ_WAKING;
            ready_q <= 1'b0;
          end
          else if (wr_pmc && reg_wdata[PMC_MODE_LSB +: PMC_MODE_W]
                   != MODE_FULL_ON)
            ready_q <= 1'b0;
        end
      endcase
    end
  end

  // Power mode field; soft reset is chip-internal and clears it too
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      power_state_select_q <= MODE_FULL_ON;
    else if (clk_en)
    begin
      if (state_q == RSQ_SOFT_RST)
        power_state_select_q <= MODE_FULL_ON;
      else if (wr_byte_test)
        power_state_select_q <= MODE_FULL_ON;
      else if (wr_pmc && state_q == RSQ_RUN)
        power_state_select_q <= reg_wdata[PMC_MODE_LSB +: PMC_MODE_W];
    end
  end

  // Immune and ordinary scratch words; only chip resets clear immune
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      immune_q <= RESET_WORD;
    else if (clk_en && wr_hardware_config && !soft_req)
      immune_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      scratch_q <= RESET_WORD;
    else if (clk_en)
    begin
      if (state_q == RSQ_SOFT_RST)
        scratch_q <= RESET_WORD;
      else if (reg_wr && reg_addr == ADDR_SCRATCH)
        scratch_q <= reg_wdata;
    end
  end

  // EEPROM probe after every chip-level or soft reset
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      eeprom_busy_q <= 1'b1;
      ee_cnt_q <= CNT_ZERO;
    end
    else if (clk_en)
    begin
      if (state_q == RSQ_SOFT_RST)
      begin
        eeprom_busy_q <= 1'b1;
        ee_cnt_q <= CNT_ZERO;
      end
      else if (eeprom_busy_q && state_q == RSQ_RUN)
      begin
        // Probe time is a stand-in; no EEPROM port in this block
        if (ee_cnt_q >= CNT_W'(EEPROM_PROBE_CYCLES - 1))
          eeprom_busy_q <= 1'b0;
        else
          ee_cnt_q <= ee_cnt_q + CNT_ONE;
      end
    end
  end

  // PHY resets; a soft reset does not touch the PHY
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      phy_rst_bit_q <= 1'b0;
      phy_reg_rst_q <= 1'b0;
      phy_cnt_q <= CNT_ZERO;
    end
    else if (clk_en)
    begin
      if (phy_rst_bit_q || phy_reg_rst_q)
      begin
        if (phy_rst_bit_q && phy_cnt_q >= CNT_W'(PHY_RST_CNT - 1))
        begin
          phy_rst_bit_q <= 1'b0;
          phy_reg_rst_q <= 1'b0;
          phy_cnt_q <= CNT_ZERO;
        end
        else if (!phy_rst_bit_q
                 && phy_cnt_q >= CNT_W'(PHY_REG_RST_CNT - 1))
        begin
          phy_reg_rst_q <= 1'b0;
          phy_cnt_q <= CNT_ZERO;
        end
        else
          phy_cnt_q <= phy_cnt_q + CNT_ONE;
      end
      else if (state_q == RSQ_RUN)
      begin
        phy_rst_bit_q <= phy_req;
        phy_reg_rst_q <= phyreg_req;
      end
    end
  end

  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      phy_basic_ctrl_q <= PHYBC_RESET;
    else if (clk_en)
    begin
      if (phy_rst_bit_q || phy_reg_rst_q)
        phy_basic_ctrl_q <= PHYBC_RESET;
      else if (wr_phybc && state_q == RSQ_RUN)
        phy_basic_ctrl_q <= reg_wdata[PHYBC_W-1:0];
    end
  end

  // Reset outputs for the rest of the chip
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      chip_rst_n_q <= 1'b0;
      soft_rst_n_q <= 1'b0;
      phy_rst_n_q <= 1'b0;
    end
    else if (clk_en)
    begin
      chip_rst_n_q <= state_q != RSQ_CHIP_RST;
      soft_rst_n_q <= state_q == RSQ_RUN || state_q == RSQ_WAKING;
      phy_rst_n_q <= state_q != RSQ_CHIP_RST
                     && !phy_rst_bit_q && !phy_reg_rst_q;
    end
  end

  // Read mux; ready reads clear during chip and soft reset, but not during PHY reset
  always_comb
  begin
    rd_d = RESET_WORD;
    unique case (reg_addr)
      ADDR_BYTE_TEST: rd_d = BYTE_TEST_VALUE;
      ADDR_HW_CONFIG:
      begin
        rd_d = immune_q;
        rd_d[HWCFG_SOFT_RST_BIT] = soft_reset_trigger_q;
      end
      ADDR_PWR_MGMT:
      begin
        // Reset outputs lag the state by a cycle; ready waits for them
        rd_d[PMC_READY_BIT] = ready_q && chip_rst_n_q
                              && soft_rst_n_q;
        rd_d[PMC_PHY_RST_BIT] = phy_rst_bit_q;
        rd_d[PMC_MODE_LSB +: PMC_MODE_W] = power_state_select_q;
      end
      ADDR_EEPROM_CMD: rd_d[EECMD_BUSY_BIT] = eeprom_busy_q;
      ADDR_PHY_BASIC_CTRL:
      begin
        rd_d[PHYBC_W-1:0] = phy_basic_ctrl_q;
        rd_d[PHYBC_RST_BIT] = phy_reg_rst_q;
      end
      ADDR_SCRATCH: rd_d = scratch_q;
      default: rd_d = RESET_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      reg_rdata_q <= RESET_WORD;
    else if (clk_en)
      reg_rdata_q <= reg_rd ? rd_d : RESET_WORD;
  end

endmodule

// File: rsq_pkg.sv
// Package for the chip-level reset sequencer: register map, fields, timing.
// Assumes a 200 MHz internal clock and a word-indexed plain register port.
package rsq_pkg;

  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Times in their own units, cycle counts derived from them
  localparam int unsigned POR_TIME_MS = 22;
  localparam int unsigned WAKE_TIME_MS = 2;
  localparam int unsigned SOFT_RST_TIME_US = 2;
  localparam int unsigned PHY_RST_TIME_US = 100;
  localparam int unsigned PHY_REG_RST_TIME_US = 100;
  localparam int unsigned EEPROM_PROBE_TIME_US = 50;
  localparam int unsigned POR_CYCLES = POR_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned WAKE_CYCLES = WAKE_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned SOFT_RST_CYCLES = SOFT_RST_TIME_US * CLK_MHZ;
  localparam int unsigned PHY_RST_CYCLES = PHY_RST_TIME_US * CLK_MHZ;
  localparam int unsigned PHY_REG_RST_CYCLES = PHY_REG_RST_TIME_US * CLK_MHZ;
  localparam int unsigned EEPROM_PROBE_CYCLES =
    EEPROM_PROBE_TIME_US * CLK_MHZ;

  localparam int unsigned CNT_W = 24;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register word addresses
  localparam logic [ADDR_W-1:0] ADDR_BYTE_TEST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_HW_CONFIG = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PWR_MGMT = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_EEPROM_CMD = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_PHY_BASIC_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 4'h5;

  // Field positions
  localparam int unsigned HWCFG_SOFT_RST_BIT = 0;
  localparam int unsigned PMC_READY_BIT = 0;
  localparam int unsigned PMC_PHY_RST_BIT = 10;
  localparam int unsigned PMC_MODE_LSB = 12;
  localparam int unsigned PMC_MODE_W = 2;
  localparam int unsigned EECMD_BUSY_BIT = 31;
  localparam int unsigned PHYBC_RST_BIT = 15;
  localparam int unsigned PHYBC_W = 16;

  localparam logic [DATA_W-1:0] BYTE_TEST_VALUE = 32'h87654321;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;
  localparam logic [PMC_MODE_W-1:0] MODE_FULL_ON = 2'h0;
  localparam logic [PHYBC_W-1:0] PHYBC_RESET = 16'h3000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

  typedef enum logic [1:0] {
    RSQ_CHIP_RST,
    RSQ_SOFT_RST,
    RSQ_WAKING,
    RSQ_RUN
  } rsq_state_type;

endpackage

// File: rsq_checker.sv
// Checker: reset timing seen at the sequencer ports.
// Assumes clk_en stays high while counts run.
`timescale 1ns/1ps
module rsq_checker
  import rsq_pkg::*;
#(
  parameter int unsigned POR_CNT = 50,
  parameter int unsigned PHY_RST_CNT = 40
)
(
  // Clock, resets, bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hw_reset_pin_n_in,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata_q,
  // Reset outputs
  input wire logic chip_rst_n_q,
  input wire logic soft_rst_n_q,
  input wire logic phy_rst_n_q,
  input wire logic hw_reset_pin_pullup_q
);
  int unsigned chip_lo_q;
  int unsigned soft_lo_q;
  int unsigned phy_lo_q;

  // Low-time counters; a chip reset voids soft and PHY spans
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      chip_lo_q <= 0;
      soft_lo_q <= 0;
      phy_lo_q <= 0;
    end
    else
    begin
      chip_lo_q <= chip_rst_n_q ? 0 : chip_lo_q + 1;
      soft_lo_q <= (soft_rst_n_q || !chip_rst_n_q) ? 0 : soft_lo_q + 1;
      phy_lo_q <= (phy_rst_n_q || !chip_rst_n_q) ? 0 : phy_lo_q + 1;
    end

  sequence rd_at(logic [ADDR_W-1:0] a);
    reg_rd && clk_en && reg_addr == a;
  endsequence

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !hw_reset_pin_n_in);

  pin_hold_a: assert property (disable iff (!rst_n)
    !hw_reset_pin_n_in |-> !chip_rst_n_q && !soft_rst_n_q && !phy_rst_n_q)
    else $error("pin low but reset released");
  por_len_a: assert property (
    $rose(chip_rst_n_q) |-> chip_lo_q >= POR_CNT)
    else $error("power-on hold too short");
  rdy_clear_a: assert property (
    rd_at(ADDR_PWR_MGMT) ##0 !chip_rst_n_q |=> !reg_rdata_q[PMC_READY_BIT])
    else $error("ready set during chip reset");
  byte_read_a: assert property (
    rd_at(ADDR_BYTE_TEST) |=> reg_rdata_q == BYTE_TEST_VALUE)
    else $error("byte test value wrong");
  soft_len_a: assert property ($rose(soft_rst_n_q) &&
    $past(chip_rst_n_q) |-> soft_lo_q >= SOFT_RST_CYCLES - 2 &&
    soft_lo_q <= SOFT_RST_CYCLES + 2)
    else $error("soft reset span wrong");
  phy_len_a: assert property ($rose(phy_rst_n_q) &&
    $past(chip_rst_n_q) |-> phy_lo_q >= PHY_RST_CNT - 1)
    else $error("phy reset too short");
  chip_order_a: assert property (
    !chip_rst_n_q |-> !soft_rst_n_q && !phy_rst_n_q)
    else $error("chip reset not covering others");
  pullup_on_a: assert property (
    chip_rst_n_q |-> hw_reset_pin_pullup_q)
    else $error("pin pull-up off");
endmodule

// File: rsq_host.sv
// Host processor model on the plain register port.
// Assumes read data stand only in the cycle after the strobe.
`timescale 1ns/1ps
module rsq_host
  import rsq_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] reg_rdata_q,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse so stale values never match
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
    @(posedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    v = reg_rdata_q;
  endtask

  // Only reads while waiting; a stuck flag is an error, not a hang
  task automatic poll(input logic [ADDR_W-1:0] a, input int b,
    input logic v, input int lim, output int n);
    logic [DATA_W-1:0] d;
    n = 0;
    do
    begin
      rd(a, d);
      n++;
    end
    while (d[b] !== v && n < lim);
    if (d[b] !== v)
      n = -1;
  endtask
endmodule

// File: test_reset_sequencer.sv
// Testbench for the reset sequencer, host model on the register port.
// Assumes the design and host model files are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_reset_sequencer
  import rsq_pkg::*;
;
  localparam int unsigned POR = 50;
  localparam int unsigned WAKE = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_n = 1'b1;
  logic en = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  logic wr;
  logic rd;
  int checks = 0;
  int fail_count = 0;
  int n;

  rsq_reset_sequencer #(.POR_CNT(POR), .WAKE_CNT(WAKE), .PHY_RST_CNT(40),
    .PHY_REG_RST_CNT(40)) u_rsq_reset_sequencer (.clk, .rst_n,
    .clk_en(en), .hw_reset_pin_n_in(pin_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdata),
    .chip_rst_n_q(), .soft_rst_n_q(), .phy_rst_n_q(),
    .hw_reset_pin_pullup_q());
  rsq_host u_rsq_host (.clk, .reg_rdata_q(rdata), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));

  initial
    forever #2.5 clk = ~clk;

  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input int b, input logic v);
    u_rsq_host.rd(a, d);
    `CHK(d[b], v)
  endtask

  task automatic pl(input logic [ADDR_W-1:0] a, input int b, input logic v,
    input int lim);
    u_rsq_host.poll(a, b, v, lim, n);
    `CHK(n > 0, 1'b1)
  endtask

  task automatic ee(input string s);
    rdc(ADDR_EEPROM_CMD, EECMD_BUSY_BIT, 1'b1);
    pl(ADDR_EEPROM_CMD, EECMD_BUSY_BIT, 1'b0, 6000);
    $display("test %s ended, checks=%0d", s, checks);
  endtask

  // Probe waits dominate; about 31000 cycles in all
  initial
  begin
    #450000;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b0);
    u_rsq_host.rd(ADDR_BYTE_TEST, d);
    `CHK(d, BYTE_TEST_VALUE)
    pl(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b1, POR);
    ee("power-on");
    u_rsq_host.wr(ADDR_SCRATCH, 32'h0000005a);
    u_rsq_host.wr(ADDR_HW_CONFIG, 32'h00000f00);
    u_rsq_host.wr(ADDR_HW_CONFIG, 32'h00000f01);
    rdc(ADDR_HW_CONFIG, HWCFG_SOFT_RST_BIT, 1'b1);
    rdc(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b0);
    pl(ADDR_HW_CONFIG, HWCFG_SOFT_RST_BIT, 1'b0, 300);
    rdc(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b1);
    u_rsq_host.rd(ADDR_HW_CONFIG, d);
    `CHK(d, 32'h00000f00)
    u_rsq_host.rd(ADDR_SCRATCH, d);
    `CHK(d, RESET_WORD)
    ee("soft");
    u_rsq_host.wr(ADDR_PWR_MGMT, 32'h00000400);
    rdc(ADDR_PWR_MGMT, PMC_PHY_RST_BIT, 1'b1);
    pl(ADDR_PWR_MGMT, PMC_PHY_RST_BIT, 1'b0, 40);
    rdc(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b1);
    u_rsq_host.wr(ADDR_PHY_BASIC_CTRL, 32'h00008000);
    rdc(ADDR_PHY_BASIC_CTRL, PHYBC_RST_BIT, 1'b1);
    pl(ADDR_PHY_BASIC_CTRL, PHYBC_RST_BIT, 1'b0, 12000);
    u_rsq_host.rd(ADDR_PHY_BASIC_CTRL, d);
    `CHK(d[PHYBC_W-1:0], PHYBC_RESET)
    $display("test phy ended, checks=%0d", checks);
    u_rsq_host.wr(ADDR_PWR_MGMT, 32'h00001000);
    rdc(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b0);
    u_rsq_host.wr(ADDR_BYTE_TEST, 32'h00000000);
    pl(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b1, WAKE / 2 + 2);
    u_rsq_host.rd(ADDR_PWR_MGMT, d);
    `CHK(d[PMC_MODE_LSB +: PMC_MODE_W], MODE_FULL_ON)
    en <= 1'b0;
    u_rsq_host.wr(ADDR_SCRATCH, 32'h00000077);
    en <= 1'b1;
    u_rsq_host.rd(ADDR_SCRATCH, d);
    `CHK(d, RESET_WORD)
    $display("test wake ended, checks=%0d", checks);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    @(posedge clk);
    rdc(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b0);
    pl(ADDR_PWR_MGMT, PMC_READY_BIT, 1'b1, POR);
    u_rsq_host.rd(4'hf, d);
    `CHK(d, RESET_WORD)
    ee("pin");
    print_verdict();
  end
endmodule

bind rsq_reset_sequencer rsq_checker #(.POR_CNT(POR_CNT),
  .PHY_RST_CNT(PHY_RST_CNT)) u_rsq_checker (.clk, .rst_n, .clk_en,
  .hw_reset_pin_n_in, .reg_addr, .reg_rd, .reg_rdata_q, .chip_rst_n_q,
  .soft_rst_n_q, .phy_rst_n_q, .hw_reset_pin_pullup_q);
